// ### design/ars_defines.svh
// register map, field positions, reset values and source codes
// of the converter reference and input selection block.
// assumes: included by bare name from the top module and the checker.
`ifndef ARS_DEFINES_SVH
`define ARS_DEFINES_SVH

// word offsets on the register bus (byte addresses)
`define ARS_ADR_W        5
`define ARS_OFS_AMP      5'h00
`define ARS_OFS_BG       5'h04
`define ARS_OFS_CHSEL    5'h08
`define ARS_OFS_PINSEL   5'h0C
`define ARS_OFS_STAT     5'h10

// amplifier and reference control register
`define ARS_AMP_EN_BIT   7
`define ARS_AMP_IN_BIT   4
`define ARS_REF_HI       3
`define ARS_REF_LO       2
`define ARS_GAIN_HI      1
`define ARS_GAIN_LO      0
`define ARS_AMP_WMASK    8'h9F
`define ARS_AMP_RST      8'h00

// bandgap control register
`define ARS_BG_EN_BIT    0
`define ARS_BG_WMASK     8'h01
`define ARS_BG_RST       8'h00

// channel select register: source in the high nibble, channel low
`define ARS_SRC_HI       7
`define ARS_SRC_LO       4
`define ARS_CH_HI        3
`define ARS_CH_LO        0
`define ARS_CHSEL_RST    8'h00
`define ARS_PINSEL_RST   16'h0000

// status word bits, all taken from the switch output flops
`define ARS_STAT_EXT     0
`define ARS_STAT_INT     1
`define ARS_STAT_FLOAT   2
`define ARS_STAT_PIN     3
`define ARS_STAT_AMP     4
`define ARS_STAT_SUPPLY  5

// byte lane width of the register bus
`define ARS_LANE_W       8

// signal source codes
`define ARS_SRC_SUPPLY   4'h1
`define ARS_SRC_SUP_HALF 4'h2
`define ARS_SRC_SUP_QTR  4'h3
`define ARS_SRC_AMP      4'h5
`define ARS_SRC_AMP_HALF 4'h6
`define ARS_SRC_AMP_QTR  4'h7
`define ARS_SRC_GND_TOP  2'h2
`define ARS_SRC_EXT_TOP  2'h3
`define ARS_SRC_EXT_LOW  2'h0

// converter reference codes; any code with the top bit set is the amp
`define ARS_REF_SUPPLY   2'h0
`define ARS_REF_PIN      2'h1

`endif

// ### design/ars_pkg.sv
// types shared by the converter reference and input selection block.
// assumes: constants come from ars_defines.svh.
package ars_pkg;

	typedef enum logic [1:0] {
		ARS_GAIN_X1,
		ARS_GAIN_X1667,
		ARS_GAIN_X2500,
		ARS_GAIN_X3333
	} ars_gain_t;

	typedef enum {
		ARS_BUS_IDLE,
		ARS_BUS_ACK
	} ars_bus_state_t;

	// controls for amplifier, bandgap and converter reference switches
	typedef struct packed {
		logic      amp_enable;
		logic      amp_in_pin;
		logic      amp_in_bandgap;
		ars_gain_t amp_gain_choice;
		logic      bandgap_enable;
		logic      ref_supply;
		logic      ref_pin;
		logic      ref_amp;
	} ars_ref_ctl_t;

	// internal signal switches in front of the converter
	typedef struct packed {
		logic supply;
		logic supply_half;
		logic supply_quarter;
		logic amp;
		logic amp_half;
		logic amp_quarter;
		logic ground;
	} ars_int_src_t;

endpackage

// ### design/ars_pin_ovr.sv
// per-pin override of the digital port function for analog inputs.
// assumes: port controls come synchronous to clk_i from the port block.
`timescale 1ns/1ns
module ars_pin_ovr #(
	parameter int NPIN = 16
) (
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	input  wire logic [NPIN-1:0] analog_sel_i,
	input  wire logic [NPIN-1:0] port_is_output_i,
	input  wire logic [NPIN-1:0] port_pull_i,
	output logic      [NPIN-1:0] pin_analog_o,
	output logic      [NPIN-1:0] pin_pull_o,
	output logic      [NPIN-1:0] pin_drive_n_o,
	output logic      [NPIN-1:0] pin_dig_in_o
);

	genvar g;
	generate
		for (g = 0; g < NPIN; g++) begin : gen_pin
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					pin_analog_o[g]  <= 1'b0;
					pin_pull_o[g]    <= 1'b0;
					pin_drive_n_o[g] <= 1'b1;
					pin_dig_in_o[g]  <= 1'b1;
				end else begin
					pin_analog_o[g]  <= analog_sel_i[g]; // R9
					pin_pull_o[g]    <= port_pull_i[g] & ~analog_sel_i[g]; // R9
					// direction is ignored once analog is chosen
					pin_drive_n_o[g] <= ~port_is_output_i[g] |
						analog_sel_i[g]; // R10
					pin_dig_in_o[g]  <= ~analog_sel_i[g]; // R9
				end
			end
		end
	endgenerate

endmodule

// ### design/ars_top.sv
// converter reference and input selection: register file on a
// classic wishbone slave, driving amplifier, bandgap, reference and
// input multiplexer switches plus the analog pin overrides.
// assumes: one clock, synchronous reset, port block inputs in domain.
//
// Functional notes
// [R1] bit 7 of amp control enables the gain amplifier; resets to 0.
// [R2] amp control bits 6 and 5 read 0 and ignore writes.
// [R3] bit 4 picks amp input: 0 reference pin, 1 bandgap voltage.
// [R4] reference select 00 supply, 01 reference pin, 1x amp output.
// [R5] internal reference selected disconnects the external pin path.
// [R6] gain select 00..11 gives gains 1, 1.667, 2.5, 3.333.
// [R7] bandgap control bit 0 enables bandgap; bits 7..1 read 0.
// [R8] software enables bandgap and waits start-up before choosing it.
// [R9] analog pin drops its digital function and its pull-high.
// [R10] analog function select overrides the port direction.
// [R11] sources 0000, 0100, 11xx route the chosen external channel.
// [R12] twelve-channel part: channel 11xx connects nothing, floating.
// [R13] internal codes route supply, fractions, amp output, or ground.
// [R14] any internal source switches off every external channel.
// [R15] control outputs follow stored fields the cycle after a write.
`timescale 1ns/1ns
`include "ars_defines.svh"
module ars_top #(
	parameter int NCH = 16
) (
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// wishbone classic slave
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [`ARS_ADR_W-1:0] wb_adr_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o,
	// port block controls for the shared analog pins
	input  wire logic [NCH-1:0]      port_is_output_i,
	input  wire logic [NCH-1:0]      port_pull_i,
	// analog switch controls
	output ars_pkg::ars_ref_ctl_t    ref_ctl_o,
	output ars_pkg::ars_int_src_t    int_src_o,
	output logic      [NCH-1:0]      ext_chan_o,
	output logic                     conv_in_float_o,
	// pin overrides
	output logic      [NCH-1:0]      pin_analog_o,
	output logic      [NCH-1:0]      pin_pull_o,
	output logic      [NCH-1:0]      pin_drive_n_o,
	output logic      [NCH-1:0]      pin_dig_in_o
);
	import ars_pkg::*;

	// only the two channel counts of the family are decoded
	generate
		if (NCH != 12 && NCH != 16) begin : gen_bad_nch
			$error("ars_top: NCH must be 12 or 16");
		end
		if (`ARS_ADR_W < $clog2(`ARS_OFS_STAT + 1)) begin : gen_bad_adr
			$error("ars_top: address too narrow for the register map");
		end
	endgenerate

	// sources 0000, 0100 and 11xx leave the external channel path in use
	function automatic logic is_external(input logic [3:0] src);
		is_external = (src[3:2] == `ARS_SRC_EXT_TOP) ||
			(!src[3] && src[1:0] == `ARS_SRC_EXT_LOW);
	endfunction

	function automatic logic ref_is_internal(input logic [1:0] code);
		ref_is_internal = (code != `ARS_REF_PIN);
	endfunction

	// one decode for every byte-wide register's write strobe
	function automatic logic byte_write(
		input logic                  we,
		input logic                  lane,
		input logic [`ARS_ADR_W-1:0] at,
		input logic [`ARS_ADR_W-1:0] target
	);
		byte_write = we && lane && (at == target);
	endfunction

	// reset image of the widest part; the narrow part uses the low bits
	localparam logic [15:0] PIN_RST = `ARS_PINSEL_RST;

	ars_bus_state_t        bus_state_r;
	logic [7:0]            amp_ctl_r;
	logic [7:0]            bg_ctl_r;
	logic [7:0]            chsel_r;
	logic [NCH-1:0]        pin_sel_r;
	logic [31:0]           rd_data_nxt;
	logic [31:0]           dat_r;
	logic                  take;
	logic                  wr;
	logic [`ARS_ADR_W-1:0] ofs;
	logic [3:0]            src;
	logic [3:0]            chan;
	logic [1:0]            ref_code;
	ars_ref_ctl_t          ref_ctl_nxt;
	ars_int_src_t          int_src_nxt;
	logic [NCH-1:0]        ext_chan_nxt;
	logic                  float_nxt;
	logic [15:0]           pin_sel_wide;
	logic                  wr_amp;
	logic                  wr_bg;
	logic                  wr_chsel;
	logic                  wr_pin;

	assign take     = wb_cyc_i & wb_stb_i & (bus_state_r == ARS_BUS_IDLE);
	assign wr       = take & wb_we_i;
	assign ofs      = {wb_adr_i[`ARS_ADR_W-1:2], 2'h0};
	assign src      = chsel_r[`ARS_SRC_HI:`ARS_SRC_LO];
	assign chan     = chsel_r[`ARS_CH_HI:`ARS_CH_LO];
	assign ref_code = amp_ctl_r[`ARS_REF_HI:`ARS_REF_LO];

	// byte-wide registers all live in lane 0
	assign wr_amp   = byte_write(wr, wb_sel_i[0], ofs, `ARS_OFS_AMP);
	assign wr_bg    = byte_write(wr, wb_sel_i[0], ofs, `ARS_OFS_BG);
	assign wr_chsel = byte_write(wr, wb_sel_i[0], ofs, `ARS_OFS_CHSEL);
	assign wr_pin   = wr && (ofs == `ARS_OFS_PINSEL);

	// answer one cycle after the request is taken, and take nothing in that answer cycle
	// so a held request is not taken twice
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_state_r <= ARS_BUS_IDLE;
		end else begin
			case (bus_state_r)
				ARS_BUS_IDLE: begin
					if (take) begin
						bus_state_r <= ARS_BUS_ACK;
					end
				end
				ARS_BUS_ACK: begin
					bus_state_r <= ARS_BUS_IDLE;
				end
				default: begin
					bus_state_r <= ARS_BUS_IDLE;
				end
			endcase
		end
	end

	// registered ack costs one wait state but keeps the bus off any path
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= take;
		end
	end

	// amplifier and reference control; unimplemented bits never store
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			amp_ctl_r <= `ARS_AMP_RST; // R1
		end else if (wr_amp) begin
			amp_ctl_r <= wb_dat_i[7:0] & `ARS_AMP_WMASK; // R2
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bg_ctl_r <= `ARS_BG_RST;
		end else if (wr_bg) begin
			bg_ctl_r <= wb_dat_i[7:0] & `ARS_BG_WMASK; // R7
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			chsel_r <= `ARS_CHSEL_RST;
		end else if (wr_chsel) begin
			chsel_r <= wb_dat_i[7:0];
		end
	end

	// one analog function bit per shared pin, set by its own byte lane
	for (genvar p = 0; p < NCH; p++) begin : gen_pin_sel
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				pin_sel_r[p] <= PIN_RST[p];
			end else if (wr_pin && wb_sel_i[p / `ARS_LANE_W]) begin
				pin_sel_r[p] <= wb_dat_i[p];
			end
		end
	end

	assign pin_sel_wide = 16'(pin_sel_r);

	// read mux; status reflects the switches actually driven
	always_comb begin
		rd_data_nxt = 32'h0000_0000;
		case (ofs)
			`ARS_OFS_AMP: begin
				rd_data_nxt[7:0] = amp_ctl_r; // R2
			end
			`ARS_OFS_BG: begin
				rd_data_nxt[7:0] = bg_ctl_r; // R7
			end
			`ARS_OFS_CHSEL: begin
				rd_data_nxt[7:0] = chsel_r;
			end
			`ARS_OFS_PINSEL: begin
				rd_data_nxt[15:0] = pin_sel_wide;
			end
			`ARS_OFS_STAT: begin
				rd_data_nxt[`ARS_STAT_EXT]    = |ext_chan_o;
				rd_data_nxt[`ARS_STAT_INT]    = |int_src_o;
				rd_data_nxt[`ARS_STAT_FLOAT]  = conv_in_float_o;
				rd_data_nxt[`ARS_STAT_PIN]    = ref_ctl_o.ref_pin;
				rd_data_nxt[`ARS_STAT_AMP]    = ref_ctl_o.ref_amp;
				rd_data_nxt[`ARS_STAT_SUPPLY] = ref_ctl_o.ref_supply;
			end
			default: begin
				rd_data_nxt = 32'h0000_0000;
			end
		endcase
	end

	// unmapped offsets answer normally with zero data
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_r <= 32'h0000_0000;
		end else if (take && !wb_we_i) begin
			dat_r <= rd_data_nxt;
		end else if (take) begin
			dat_r <= 32'h0000_0000;
		end
	end

	assign wb_dat_o = dat_r;

	// amplifier, bandgap and converter reference switches
	always_comb begin
		ref_ctl_nxt                 = '0;
		ref_ctl_nxt.amp_enable      = amp_ctl_r[`ARS_AMP_EN_BIT]; // R1
		ref_ctl_nxt.amp_in_pin      = ~amp_ctl_r[`ARS_AMP_IN_BIT]; // R3
		// bandgap readiness is software's job; no hardware hold-off
		ref_ctl_nxt.amp_in_bandgap  = amp_ctl_r[`ARS_AMP_IN_BIT]; // R3 R8
		ref_ctl_nxt.amp_gain_choice =
			ars_gain_t'(amp_ctl_r[`ARS_GAIN_HI:`ARS_GAIN_LO]); // R6
		ref_ctl_nxt.bandgap_enable  = bg_ctl_r[`ARS_BG_EN_BIT]; // R7
		ref_ctl_nxt.ref_supply      = (ref_code == `ARS_REF_SUPPLY); // R4
		// external pin path only while the pin is the chosen reference
		ref_ctl_nxt.ref_pin         = ~ref_is_internal(ref_code); // R4 R5
		ref_ctl_nxt.ref_amp         = ref_code[1]; // R4
	end

	// internal signal sources in front of the converter
	always_comb begin
		int_src_nxt = '0;
		case (src)
			`ARS_SRC_SUPPLY: begin
				int_src_nxt.supply = 1'b1; // R13
			end
			`ARS_SRC_SUP_HALF: begin
				int_src_nxt.supply_half = 1'b1; // R13
			end
			`ARS_SRC_SUP_QTR: begin
				int_src_nxt.supply_quarter = 1'b1; // R13
			end
			`ARS_SRC_AMP: begin
				int_src_nxt.amp = 1'b1; // R13
			end
			`ARS_SRC_AMP_HALF: begin
				int_src_nxt.amp_half = 1'b1; // R13
			end
			`ARS_SRC_AMP_QTR: begin
				int_src_nxt.amp_quarter = 1'b1; // R13
			end
			default: begin
				int_src_nxt.ground =
					(src[3:2] == `ARS_SRC_GND_TOP); // R13
			end
		endcase
	end

	// external channel switches; never closed with an internal source
	always_comb begin
		ext_chan_nxt = '0;
		float_nxt    = 1'b0;
		if (is_external(src)) begin // R11 R14
			if (int'(chan) < NCH) begin
				ext_chan_nxt[chan] = 1'b1; // R11
			end else begin
				float_nxt = 1'b1; // R12
			end
		end
	end

	// every switch control is a flop loaded from the stored fields
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ref_ctl_o <= '0;
		end else begin
			ref_ctl_o <= ref_ctl_nxt; // R15
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			int_src_o <= '0;
		end else begin
			int_src_o <= int_src_nxt; // R15
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_chan_o <= '0;
		end else begin
			ext_chan_o <= ext_chan_nxt; // R15
		end
	end

	// only the narrow part can float; the wide part decodes every code
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			conv_in_float_o <= 1'b0;
		end else begin
			conv_in_float_o <= float_nxt; // R12 R15
		end
	end

	ars_pin_ovr #(
		.NPIN (NCH)
	) u_pin_ovr (
		.clk_i            (clk_i),
		.rst_i            (rst_i),
		.analog_sel_i     (pin_sel_r),
		.port_is_output_i (port_is_output_i),
		.port_pull_i      (port_pull_i),
		.pin_analog_o     (pin_analog_o),
		.pin_pull_o       (pin_pull_o),
		.pin_drive_n_o    (pin_drive_n_o),
		.pin_dig_in_o     (pin_dig_in_o)
	);

endmodule

// ### tb/ars_top_assertions.sv
// port checker for the reference and input selection block
// assumes: bound into ars_top, one clock, sync active-high reset
`timescale 1ns/1ns
`include "ars_defines.svh"
module ars_chk #(
	parameter int NCH = 16
) (
	input wire logic                  clk_i,
	input wire logic                  rst_i,
	input wire logic                  wb_cyc_i,
	input wire logic                  wb_stb_i,
	input wire logic                  wb_we_i,
	input wire logic [3:0]            wb_sel_i,
	input wire logic [`ARS_ADR_W-1:0] wb_adr_i,
	input wire logic [31:0]           wb_dat_i,
	input wire logic [31:0]           wb_dat_o,
	input wire logic                  wb_ack_o,
	input wire logic [NCH-1:0]        port_is_output_i,
	input wire logic [NCH-1:0]        port_pull_i,
	input wire ars_pkg::ars_ref_ctl_t ref_ctl_o,
	input wire ars_pkg::ars_int_src_t int_src_o,
	input wire logic [NCH-1:0]        ext_chan_o,
	input wire logic                  conv_in_float_o,
	input wire logic [NCH-1:0]        pin_analog_o,
	input wire logic [NCH-1:0]        pin_pull_o,
	input wire logic [NCH-1:0]        pin_drive_n_o,
	input wire logic [NCH-1:0]        pin_dig_in_o
);
	import ars_pkg::*;
	logic [31:0] dat_q;
	logic        wr_c;
	assign wr_c = wb_ack_o & wb_we_i & wb_sel_i[0];
	// keeps the acked write data, so no slice goes through $past
	always_ff @(posedge clk_i) begin
		dat_q <= wb_dat_i;
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence amp_wr_s;
		wr_c && wb_adr_i[4:2] == 3'h0;
	endsequence
	sequence bg_wr_s;
		wr_c && wb_adr_i[4:2] == 3'h1;
	endsequence
	amp_write_a: assert property (amp_wr_s |=>
		ref_ctl_o.amp_enable == dat_q[7] && ref_ctl_o.amp_in_bandgap ==
		dat_q[4] && ref_ctl_o.amp_gain_choice == dat_q[1:0])
		else $error("amp control not as written");
	ref_write_a: assert property (amp_wr_s |=>
		ref_ctl_o.ref_amp == dat_q[3] && ref_ctl_o.ref_pin ==
		(dat_q[3:2] == 2'h1)) else $error("reference not as written");
	bg_write_a: assert property (bg_wr_s |=>
		ref_ctl_o.bandgap_enable == dat_q[0])
		else $error("bandgap enable not as written");
	read_zero_a: assert property (wb_ack_o && !wb_we_i &&
		wb_adr_i[4:3] == 2'h0 |-> wb_dat_o[31:8] == 24'h0 &&
		wb_dat_o[6:5] == 2'h0 && (!wb_adr_i[2] || wb_dat_o[7:1] == 7'h0))
		else $error("unimplemented bits read nonzero");
	ref_onehot_a: assert property (!$past(rst_i) && !$past(rst_i, 2)
		|-> $onehot({ref_ctl_o.ref_supply, ref_ctl_o.ref_pin,
		ref_ctl_o.ref_amp}) && ref_ctl_o.amp_in_pin != ref_ctl_o.amp_in_bandgap)
		else $error("reference or amp input not exclusive");
	int_excl_a: assert property (int_src_o != 7'h0 |->
		ext_chan_o == '0 && !conv_in_float_o)
		else $error("external channel joined internal signal");
	src_onehot_a: assert property ($onehot0(int_src_o) &&
		$onehot0(ext_chan_o)) else $error("source switches not one-hot");
	pin_pull_a: assert property (!$past(rst_i) |-> pin_pull_o ==
		($past(port_pull_i) & ~pin_analog_o) && pin_dig_in_o == ~pin_analog_o)
		else $error("analog pin kept pull or digital input");
	pin_drive_a: assert property (!$past(rst_i) |-> pin_drive_n_o ==
		(~$past(port_is_output_i) | pin_analog_o))
		else $error("analog pin still driven");
	float_off_a: assert property (NCH == 16 |-> !conv_in_float_o)
		else $error("floating flagged on full channel part");
endmodule
bind ars_top ars_chk #(.NCH(NCH)) chk_u (.*);

// ### tb/tb.sv
// self-checking bench for the reference and input selection block
// assumes: ars_top with sixteen channels, wishbone driven from here
`timescale 1ns/1ns
module tb;
	import ars_pkg::*;
	typedef struct packed {
		logic [4:0]  adr;
		logic [15:0] wd;
		logic [15:0] rd;
		logic [22:0] sw;
	} ars_row_t;
	logic         clk_i = 1'b0;
	logic         rst_i = 1'b1;
	logic         wb_cyc = 1'b0;
	logic         wb_stb = 1'b0;
	logic         wb_we = 1'b0;
	logic [3:0]   wb_sel = 4'h0;
	logic [4:0]   wb_adr = 5'h00;
	logic [31:0]  wb_wd = 32'h0;
	logic [15:0]  p_out = 16'hFFFF;
	logic [15:0]  p_pull = 16'hFFFF;
	logic [31:0]  wb_rd, q;
	logic         wb_ack, flt;
	logic [15:0]  ext, pa, pp, pdn, pdi;
	ars_ref_ctl_t rc;
	ars_int_src_t isrc;
	int           err_total = 0;
	int           num_checks = 0;
	// bandgap first so it is running before the amp picks it
	ars_row_t rows [20] = '{
		'{5'h04, 16'hFF, 16'h01, 23'h08C}, '{5'h00, 16'hFF, 16'h9F, 23'h179},
		'{5'h00, 16'h04, 16'h04, 23'h08A}, '{5'h00, 16'h69, 16'h09, 23'h099},
		'{5'h00, 16'h12, 16'h12, 23'h06C}, '{5'h04, 16'hFE, 16'h00, 23'h064},
		'{5'h08, 16'h05, 16'h05, 23'h20}, '{5'h08, 16'h4F, 16'h4F, 23'h8000},
		'{5'h08, 16'hC0, 16'hC0, 23'h1}, '{5'h08, 16'hF9, 16'hF9, 23'h200},
		'{5'h08, 16'h1A, 16'h1A, 23'h400000},
		'{5'h08, 16'h2F, 16'h2F, 23'h200000},
		'{5'h08, 16'h33, 16'h33, 23'h100000},
		'{5'h08, 16'h57, 16'h57, 23'h080000},
		'{5'h08, 16'h6C, 16'h6C, 23'h040000},
		'{5'h08, 16'h71, 16'h71, 23'h020000},
		'{5'h08, 16'h8F, 16'h8F, 23'h010000},
		'{5'h08, 16'hB3, 16'hB3, 23'h010000},
		'{5'h10, 16'hFF, 16'h22, 23'h0}, '{5'h14, 16'hFF, 16'h00, 23'h0}};
	ars_top #(.NCH(16)) dut_u (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_sel_i(wb_sel), .wb_adr_i(wb_adr),
		.wb_dat_i(wb_wd), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack),
		.port_is_output_i(p_out), .port_pull_i(p_pull), .ref_ctl_o(rc),
		.int_src_o(isrc), .ext_chan_o(ext), .conv_in_float_o(flt),
		.pin_analog_o(pa), .pin_pull_o(pp), .pin_drive_n_o(pdn),
		.pin_dig_in_o(pdi));
	always #10 clk_i = ~clk_i;
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("Error at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	// request stands until ack is seen at a rising edge; data is taken
	// there; only the watchdog limits the wait
	task automatic wb(input logic [4:0] a, input logic w,
		input logic [3:0] s, input logic [15:0] d, output logic [31:0] r);
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_sel <= s;
		wb_adr <= a;
		wb_wd <= {16'h0, d};
		do begin
			@(posedge clk_i);
		end while (wb_ack !== 1'b1);
		r = wb_rd;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk_i);
		chk(32'(rc), 32'h0);
		chk({pdn, pdi}, 32'hFFFFFFFF);
		chk({pp, pa}, 32'h0);
		rst_i <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			wb(5'(k * 4), 1'b0, 4'hF, 16'h0, q);
			chk(q, 32'h0);
		end
		chk(32'(rc), 32'h084);
		chk(32'(ext), 32'h1);
		$display("test reset done");
		foreach (rows[i]) begin
			wb(rows[i].adr, 1'b1, 4'hF, rows[i].wd, q);
			wb(rows[i].adr, 1'b0, 4'hF, 16'h0, q);
			chk(q, 32'(rows[i].rd));
			if (rows[i].adr < 5'h08)
				chk(32'(rc), 32'(rows[i].sw));
			else if (rows[i].adr == 5'h08)
				chk(32'({flt, isrc, ext}), 32'(rows[i].sw));
		end
		$display("test table done");
		wb(5'h00, 1'b1, 4'hE, 16'h80, q);
		wb(5'h00, 1'b0, 4'hF, 16'h0, q);
		chk(q, 32'h12);
		wb(5'h0C, 1'b1, 4'hF, 16'hA5C3, q);
		wb(5'h0C, 1'b1, 4'h2, 16'h0, q);
		wb(5'h0C, 1'b0, 4'hF, 16'h0, q);
		chk(q, 32'h00C3);
		@(negedge clk_i);
		chk({pa, pp}, 32'h00C3FF3C);
		chk({pdn, pdi}, 32'h00C3FF3C);
		@(posedge clk_i);
		p_out <= 16'h0;
		p_pull <= 16'h0;
		repeat (3) @(negedge clk_i);
		chk({pdn, pp}, 32'hFFFF0000);
		$display("test pins done");
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(5'h00, 1'b0, 4'hF, 16'h0, q);
		chk(q, 32'h0);
		chk(32'(rc), 32'h084);
		chk(32'(ext), 32'h1);
		chk({pa, pp}, 32'h0);
		$display("test midreset done");
		give_verdict;
	end
	initial begin
		// the tests need some 175 cycles; this leaves a wide margin
		repeat (5000) @(posedge clk_i);
		err_total++;
		give_verdict;
	end
endmodule
